// File: design/dwr_bank.sv
// Dual 64-tap wiper register bank behind a two-wire serial slave.
// Assumes an external pull-up on the data line and a slow bus clock.
`timescale 1ns/1ps
`default_nettype none

module dwr_bank
#(
  parameter int          TAPS     = dwr_pkg::TAPS,
  // Fixed upper slave address bits; value is arbitrary
  parameter logic [2:0]  DEV_TYPE = dwr_pkg::DEV_TYPE_DFLT,
  parameter logic [47:0] NV_INIT  = dwr_pkg::NV_RESET_DFLT
)
(
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output wire logic        sda_out,
  output wire logic        sda_oe_n,
  input  wire logic        addr_select_bit0,
  input  wire logic        addr_select_bit1,
  input  wire logic        addr_select_bit2,
  input  wire logic        addr_select_bit3,
  output wire logic [5:0]  wiper_position0,
  output wire logic [5:0]  wiper_position1,
  output wire logic [63:0] tap_select0,
  output wire logic [63:0] tap_select1
);

  if (TAPS != (1 << dwr_pkg::WIPER_W))
  begin : g_chk
    $error("TAPS must equal two to the wiper width");
  end

  dwr_pkg::dwr_core_type r_reg;
  dwr_pkg::dwr_core_type r_next;
  dwr_pkg::dwr_bus_type  bus;

  // One-hot tap decode of a wiper value
  function automatic logic [63:0] tap_decode(input logic [5:0] v);
    tap_decode = dwr_pkg::TAP_RESET << v;
  endfunction

  // Single step that holds at either end instead of wrapping
  function automatic logic [5:0] wiper_step(input logic [5:0] v,
                                            input logic       up);
    logic [5:0] res;
    res = v;
    if (up && v != dwr_pkg::WIPER_MAX)
      res = 6'(v + 6'h01);
    else if (!up && v != dwr_pkg::WIPER_MIN)
      res = 6'(v - 6'h01);
    wiper_step = res;
  endfunction

  // Pins are asynchronous, so they pass the synchroniser first
  dwr_sync u_sync
  (
    .ref_clk     (ref_clk),
    .rst         (rst),
    .scl_in      (scl_in),
    .sda_in      (sda_in),
    .addr_sel_in ({addr_select_bit3, addr_select_bit2,
                   addr_select_bit1, addr_select_bit0}),
    .bus         (bus)
  );

  // Serial slave sequencing and register updates
  always_comb
  begin
    logic [3:0] op;
    op     = 4'h0;
    r_next = r_reg;
    case (r_reg.fsm)
      dwr_pkg::ST_RECALL:
      begin
        for (int c = 0; c < dwr_pkg::NUM_CH; c++)
          r_next.wiper[c] = r_reg.stored[c][0];
        r_next.fsm = dwr_pkg::ST_IDLE;
      end
      dwr_pkg::ST_ADDR, dwr_pkg::ST_INSTR, dwr_pkg::ST_DATA:
      begin
        if (bus.scl_rise)
        begin
          r_next.sh  = {r_reg.sh[6:0], bus.sda};
          r_next.cnt = 4'(r_reg.cnt + 4'h1);
        end
        else if (bus.scl_fall && r_reg.cnt == dwr_pkg::CNT_BYTE)
        begin
          r_next.cnt = dwr_pkg::CNT_RESET;
          r_next.fsm = dwr_pkg::ST_IDLE;
          if (r_reg.fsm == dwr_pkg::ST_ADDR)
          begin
            // Foreign addresses are left unanswered
            if (r_reg.sh[7:1] == {DEV_TYPE, bus.addr_sel})
            begin
              r_next.rw   = r_reg.sh[dwr_pkg::RW_BIT];
              r_next.oe_n = 1'b0;
              r_next.fsm  = dwr_pkg::ST_ADDR_ACK;
            end
          end
          else if (r_reg.fsm == dwr_pkg::ST_INSTR)
          begin
            op = r_reg.sh[dwr_pkg::OP_MSB:dwr_pkg::OP_LSB];
            r_next.op  = op;
            r_next.ch  = r_reg.sh[dwr_pkg::CH_BIT];
            r_next.idx = r_reg.sh[dwr_pkg::IDX_MSB:dwr_pkg::IDX_LSB];
            r_next.oe_n = 1'b0;
            r_next.fsm  = dwr_pkg::ST_INSTR_ACK;
            case (op)
              dwr_pkg::OP_READ_WIPER:
                r_next.rd_byte = {2'h0, r_reg.wiper[r_next.ch]};
              dwr_pkg::OP_READ_SET:
                r_next.rd_byte =
                  {2'h0, r_reg.stored[r_next.ch][r_next.idx]};
              dwr_pkg::OP_SET_TO_WIPER:
                r_next.wiper[r_next.ch] =
                  r_reg.stored[r_next.ch][r_next.idx];
              dwr_pkg::OP_WIPER_TO_SET:
                r_next.stored[r_next.ch][r_next.idx] =
                  r_reg.wiper[r_next.ch];
              dwr_pkg::OP_WRITE_WIPER, dwr_pkg::OP_WRITE_SET,
              dwr_pkg::OP_INC_DEC:
                r_next.oe_n = 1'b0;
              default:
              begin
                // Unknown opcode: no acknowledge
                r_next.oe_n = 1'b1;
                r_next.fsm  = dwr_pkg::ST_IDLE;
              end
            endcase
          end
          else
          begin
            r_next.oe_n = 1'b0;
            r_next.fsm  = dwr_pkg::ST_DATA_ACK;
            case (r_reg.op)
              dwr_pkg::OP_WRITE_WIPER:
                r_next.wiper[r_reg.ch] = r_reg.sh[5:0];
              dwr_pkg::OP_WRITE_SET:
                r_next.stored[r_reg.ch][r_reg.idx] =
                  r_reg.sh[5:0];
              dwr_pkg::OP_INC_DEC:
                // Each data byte is one step; bit 0 picks the direction
                r_next.wiper[r_reg.ch] =
                  wiper_step(r_reg.wiper[r_reg.ch],
                             r_reg.sh[dwr_pkg::INC_BIT]);
              default:
              begin
                r_next.oe_n = 1'b1;
                r_next.fsm  = dwr_pkg::ST_IDLE;
              end
            endcase
          end
        end
      end
      dwr_pkg::ST_ADDR_ACK, dwr_pkg::ST_INSTR_ACK, dwr_pkg::ST_DATA_ACK:
      begin
        if (bus.scl_fall)
        begin
          r_next.oe_n = 1'b1;
          r_next.fsm  = (r_reg.fsm == dwr_pkg::ST_ADDR_ACK)
                        ? dwr_pkg::ST_INSTR : dwr_pkg::ST_DATA;
          if (r_reg.fsm == dwr_pkg::ST_ADDR_ACK && r_reg.rw)
          begin
            r_next.sh   = r_reg.rd_byte;
            r_next.oe_n = r_reg.rd_byte[7];
            r_next.fsm  = dwr_pkg::ST_TX;
          end
        end
      end
      dwr_pkg::ST_TX:
      begin
        if (bus.scl_rise)
          r_next.cnt = 4'(r_reg.cnt + 4'h1);
        else if (bus.scl_fall && r_reg.cnt == dwr_pkg::CNT_BYTE)
        begin
          r_next.cnt    = dwr_pkg::CNT_RESET;
          r_next.oe_n   = 1'b1;
          r_next.ack_ok = 1'b0;
          r_next.fsm    = dwr_pkg::ST_TX_ACK;
        end
        else if (bus.scl_fall && r_reg.cnt != dwr_pkg::CNT_RESET)
        begin
          // New bit goes out on the falling clock edge
          r_next.sh   = {r_reg.sh[6:0], 1'b0};
          r_next.oe_n = r_reg.sh[6];
        end
      end
      dwr_pkg::ST_TX_ACK:
      begin
        if (bus.scl_rise)
          r_next.ack_ok = ~bus.sda;
        else if (bus.scl_fall)
        begin
          // Master acknowledge repeats the byte; no acknowledge ends it
          r_next.fsm = r_reg.ack_ok ? dwr_pkg::ST_TX : dwr_pkg::ST_IDLE;
          if (r_reg.ack_ok)
          begin
            r_next.sh   = r_reg.rd_byte;
            r_next.oe_n = r_reg.rd_byte[7];
          end
        end
      end
      dwr_pkg::ST_IDLE:
        r_next.oe_n = 1'b1;
      default:
      begin
        r_next.oe_n = 1'b1;
        r_next.fsm  = dwr_pkg::ST_IDLE;
      end
    endcase
    // Framing conditions override any byte in progress
    if (r_reg.fsm != dwr_pkg::ST_RECALL)
    begin
      if (bus.stop)
      begin
        r_next.oe_n = 1'b1;
        r_next.fsm  = dwr_pkg::ST_IDLE;
      end
      else if (bus.start)
      begin
        r_next.oe_n = 1'b1;
        r_next.cnt  = dwr_pkg::CNT_RESET;
        r_next.fsm  = dwr_pkg::ST_ADDR;
      end
    end
    // Tap select follows the wiper in the same edge
    for (int c = 0; c < dwr_pkg::NUM_CH; c++)
      r_next.tap_sel[c] = tap_decode(r_next.wiper[c]);
  end

  // All state registered together; stored settings start from NV_INIT
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      r_reg         <= '0;
      r_reg.fsm     <= dwr_pkg::ST_RECALL;
      r_reg.oe_n    <= 1'b1;
      r_reg.stored  <= NV_INIT;
      r_reg.wiper   <= {dwr_pkg::WIPER_RESET, dwr_pkg::WIPER_RESET};
      r_reg.tap_sel <= {dwr_pkg::TAP_RESET, dwr_pkg::TAP_RESET};
    end
    else
    begin
      r_reg <= r_next;
    end
  end

  // Open drain: the output level is always low, only the enable moves
  assign sda_out         = 1'b0;
  assign sda_oe_n        = r_reg.oe_n;
  assign wiper_position0 = r_reg.wiper[0];
  assign wiper_position1 = r_reg.wiper[1];
  assign tap_select0     = r_reg.tap_sel[0];
  assign tap_select1     = r_reg.tap_sel[1];

endmodule

`default_nettype wire

// File: design/dwr_pkg.sv
// Constants, encodings and carrier types of the dual wiper register bank.
// Assumes a single 250 MHz core clock; the serial bus is sampled on it.
package dwr_pkg;

  // Widths and counts
  localparam int WIPER_W = 6;
  localparam int NUM_CH  = 2;
  localparam int NUM_SET = 4;
  localparam int TAPS    = 64;

  // Bit counter values within one serial byte
  localparam logic [3:0] CNT_RESET = 4'h0;
  localparam logic [3:0] CNT_BYTE  = 4'h8;

  // Instruction byte: opcode in [7:4], setting index in [3:2], channel in [0]
  localparam int OP_MSB  = 7;
  localparam int OP_LSB  = 4;
  localparam int IDX_MSB = 3;
  localparam int IDX_LSB = 2;
  localparam int CH_BIT  = 0;
  localparam int RW_BIT  = 0;
  localparam int INC_BIT = 0;

  // Instruction opcodes
  localparam logic [3:0] OP_READ_WIPER   = 4'h9;
  localparam logic [3:0] OP_WRITE_WIPER  = 4'ha;
  localparam logic [3:0] OP_READ_SET     = 4'hb;
  localparam logic [3:0] OP_WRITE_SET    = 4'hc;
  localparam logic [3:0] OP_SET_TO_WIPER = 4'hd;
  localparam logic [3:0] OP_WIPER_TO_SET = 4'he;
  localparam logic [3:0] OP_INC_DEC      = 4'h2;

  // Wiper limits and values after reset
  localparam logic [5:0]  WIPER_MIN       = 6'h00;
  localparam logic [5:0]  WIPER_MAX       = 6'h3f;
  localparam logic [5:0]  WIPER_RESET     = 6'h00;
  localparam logic [63:0] TAP_RESET       = 64'h1;
  localparam logic [47:0] NV_RESET_DFLT   = 48'h820820820820;
  localparam logic [2:0]  DEV_TYPE_DFLT   = 3'h5; // Arbitrary address bits

  typedef enum logic [3:0] {
    ST_RECALL, ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_INSTR, ST_INSTR_ACK,
    ST_DATA, ST_DATA_ACK, ST_TX, ST_TX_ACK
  } dwr_fsm_type;

  // Cleaned serial bus events seen by the core
  typedef struct packed {
    logic       scl;
    logic       sda;
    logic       scl_rise;
    logic       scl_fall;
    logic       start;
    logic       stop;
    logic [3:0] addr_sel;
  } dwr_bus_type;

  // Synchroniser state
  typedef struct packed {
    logic [2:0]  scl_sh;
    logic [2:0]  sda_sh;
    logic [3:0]  sel_s1;
    logic [3:0]  sel_s2;
    dwr_bus_type bus;
  } dwr_sync_type;

  // Core state
  typedef struct packed {
    dwr_fsm_type                          fsm;
    logic [3:0]                           cnt;
    logic [7:0]                           sh;
    logic                                 rw;
    logic [3:0]                           op;
    logic                                 ch;
    logic [1:0]                           idx;
    logic [7:0]                           rd_byte;
    logic                                 ack_ok;
    logic                                 oe_n;
    logic [NUM_CH-1:0][WIPER_W-1:0]               wiper;
    logic [NUM_CH-1:0][NUM_SET-1:0][WIPER_W-1:0]  stored;
    logic [NUM_CH-1:0][TAPS-1:0]                  tap_sel;
  } dwr_core_type;

endpackage

// File: design/dwr_sync.sv
// Two-flop synchronisers and edge detection for the serial pins.
// Assumes scl and sda are asynchronous to ref_clk and much slower.
`timescale 1ns/1ps
`default_nettype none

module dwr_sync
(
  input  wire logic         ref_clk,
  input  wire logic         rst,
  input  wire logic         scl_in,
  input  wire logic         sda_in,
  input  wire logic [3:0]   addr_sel_in,
  output var dwr_pkg::dwr_bus_type bus
);

  dwr_pkg::dwr_sync_type s_reg;
  dwr_pkg::dwr_sync_type s_next;

  // Edges use stages 1 and 2 only; stage 0 feeds nothing but stage 1
  always_comb
  begin
    s_next              = s_reg;
    s_next.scl_sh       = {s_reg.scl_sh[1:0], scl_in};
    s_next.sda_sh       = {s_reg.sda_sh[1:0], sda_in};
    s_next.sel_s1       = addr_sel_in;
    s_next.sel_s2       = s_reg.sel_s1;
    s_next.bus.scl      = s_reg.scl_sh[1];
    s_next.bus.sda      = s_reg.sda_sh[1];
    s_next.bus.scl_rise = s_reg.scl_sh[1] & ~s_reg.scl_sh[2];
    s_next.bus.scl_fall = ~s_reg.scl_sh[1] & s_reg.scl_sh[2];
    // Data moving while the clock stays high frames a transfer
    s_next.bus.start    = s_reg.scl_sh[1] & s_reg.scl_sh[2] &
                          ~s_reg.sda_sh[1] & s_reg.sda_sh[2];
    s_next.bus.stop     = s_reg.scl_sh[1] & s_reg.scl_sh[2] &
                          s_reg.sda_sh[1] & ~s_reg.sda_sh[2];
    s_next.bus.addr_sel = s_reg.sel_s2;
  end

  // Idle bus reads high after reset
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      s_reg <= '{scl_sh: 3'h7, sda_sh: 3'h7, sel_s1: 4'h0, sel_s2: 4'h0,
                 bus: '{scl: 1'b1, sda: 1'b1, scl_rise: 1'b0,
                        scl_fall: 1'b0, start: 1'b0, stop: 1'b0,
                        addr_sel: 4'h0}};
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  assign bus = s_reg.bus;

endmodule

`default_nettype wire

// File: verif/dwr_bank_bench.sv
// Self-checking bench for the dual wiper register bank.
// Assumes the master model and the bound port checker.
`timescale 1ns/1ps
`default_nettype none
module dwr_bank_bench;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic [3:0]  sel = 4'h0;
  logic        scl, pull, sda_oe_n, sda_out, ack, up;
  logic [5:0]  w0, w1, v, e0, e1;
  logic [63:0] t0, t1;
  logic [7:0]  rb;
  wire logic   sda = ~pull & (sda_oe_n | sda_out);
  int          err_count = 0;
  int          comparisons = 0;
  int          cyc = 0;
  always #2 ref_clk = ~ref_clk;
  dwr_master_model u_dwr_master_model (.scl(scl), .sda_pull(pull), .sda(sda));
  dwr_bank u_dwr_bank
  (
    .ref_clk(ref_clk), .rst(rst), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .addr_select_bit0(sel[0]), .addr_select_bit1(sel[1]),
    .addr_select_bit2(sel[2]), .addr_select_bit3(sel[3]),
    .wiper_position0(w0), .wiper_position1(w1),
    .tap_select0(t0), .tap_select1(t1)
  );
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out;
    $display("Checks %0d, mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Hang guard well above the expected run length
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 90000)
    begin
      err_count++;
      close_out();
    end
  end
  function automatic logic [63:0] tap(input logic [5:0] w);
    return 64'h1 << w;
  endfunction
  // Stepping stops at the ends instead of wrapping
  function automatic logic [5:0] step(input logic [5:0] w, input logic u);
    if (u)
      return (w == 6'h3f) ? w : w + 6'h01;
    return (w == 6'h00) ? w : w - 6'h01;
  endfunction
  // Write frame; a foreign address must stay unanswered throughout
  task automatic frame(input logic [3:0] a, input logic [7:0] ins,
                       input logic [7:0] d, input int n, input logic ok);
    u_dwr_master_model.start();
    u_dwr_master_model.put_byte({dwr_pkg::DEV_TYPE_DFLT, a, 1'b0}, ack);
    check(64'(ack), 64'(!ok));
    u_dwr_master_model.put_byte(ins, ack);
    check(64'(ack), 64'(!ok));
    for (int i = 0; i < n; i++)
    begin
      u_dwr_master_model.put_byte(d, ack);
      check(64'(ack), 64'(!ok));
    end
    u_dwr_master_model.stop();
  endtask
  task automatic rd(input logic [7:0] ins, input logic [5:0] exp);
    frame(sel, ins, 8'h00, 0, 1'b1);
    u_dwr_master_model.start();
    u_dwr_master_model.put_byte({dwr_pkg::DEV_TYPE_DFLT, sel, 1'b1}, ack);
    check(64'(ack), 64'h0);
    // Master acknowledge asks for the same byte once more
    u_dwr_master_model.get_byte(1'b0, rb);
    check(64'(rb), 64'(exp));
    u_dwr_master_model.get_byte(1'b1, rb);
    u_dwr_master_model.stop();
    check(64'(rb), 64'(exp));
  endtask
  task automatic wcheck;
    check(64'(w0), 64'(e0));
    check(64'(w1), 64'(e1));
    check(t0, tap(e0));
    check(t1, tap(e1));
  endtask
  initial
  begin
    void'($urandom(32'haa102551));
    repeat (5) @(posedge ref_clk);
    #1 rst = 1'b0;
    sel = 4'($urandom());
    e0 = 6'h20;
    e1 = 6'h20;
    repeat (20) @(posedge ref_clk);
    #1 wcheck();
    e1 = 6'($urandom());
    frame(sel, 8'ha1, {2'b11, e1}, 1, 1'b1);
    wcheck();
    rd(8'h91, e1);
    rd(8'h90, e0);
    for (int k = 0; k < 4; k++)
    begin
      v = 6'($urandom());
      frame(sel, {4'hc, 2'(k), 2'b00}, {2'b00, v}, 1, 1'b1);
      rd({4'hb, 2'(k), 2'b00}, v);
      frame(sel, {4'hd, 2'(k), 2'b00}, 8'h00, 0, 1'b1);
      e0 = v;
      wcheck();
    end
    frame(sel, 8'he5, 8'h00, 0, 1'b1);
    rd(8'hb5, e1);
    for (int i = 0; i < 3; i++)
    begin
      v = (i == 0) ? 6'h3e : (i == 1) ? 6'h01 : 6'($urandom());
      up = (i == 0) ? 1'b1 : (i == 1) ? 1'b0 : 1'($urandom());
      frame(sel, 8'ha0, {2'b00, v}, 1, 1'b1);
      frame(sel, 8'h20, {7'h00, up}, 3, 1'b1);
      e0 = step(step(step(v, up), up), up);
      wcheck();
    end
    for (int b = 0; b < 4; b++)
    begin
      frame(sel ^ (4'h1 << b), 8'ha1, 8'h3f, 1, 1'b0);
      wcheck();
    end
    // Unknown opcode: address answered, instruction refused
    u_dwr_master_model.start();
    u_dwr_master_model.put_byte({dwr_pkg::DEV_TYPE_DFLT, sel, 1'b0}, ack);
    check(64'(ack), 64'h0);
    u_dwr_master_model.put_byte(8'h71, ack);
    check(64'(ack), 64'h1);
    u_dwr_master_model.stop();
    wcheck();
    repeat (4)
    begin
      v = 6'($urandom());
      up = 1'($urandom());
      frame(sel, {7'h50, up}, {2'b00, v}, 1, 1'b1);
      if (up)
        e1 = v;
      else
        e0 = v;
      wcheck();
    end
    close_out();
  end
endmodule
`default_nettype wire

// File: verif/dwr_bank_properties.sv
// Port checker for the dual wiper register bank.
// Assumes it is bound onto dwr_bank; one clock domain only.
`timescale 1ns/1ps
`default_nettype none
module dwr_bank_properties
#(
  parameter logic [47:0] NV_INIT = dwr_pkg::NV_RESET_DFLT
)
(
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic        scl_in,
  input wire logic        sda_in,
  input wire logic        sda_out,
  input wire logic        sda_oe_n,
  input wire logic        addr_select_bit0,
  input wire logic        addr_select_bit1,
  input wire logic        addr_select_bit2,
  input wire logic        addr_select_bit3,
  input wire logic [5:0]  wiper_position0,
  input wire logic [5:0]  wiper_position1,
  input wire logic [63:0] tap_select0,
  input wire logic [63:0] tap_select1
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic [3:0] age_reg;
  logic [5:0] hi_reg;
  // Age since reset masks the recall; hi counts an idle clock line
  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
    begin
      age_reg <= 4'h0;
      hi_reg  <= 6'h00;
    end
    else
    begin
      age_reg <= (age_reg == 4'hf) ? age_reg : age_reg + 4'h1;
      hi_reg  <= !scl_in ? 6'h00 :
                 (hi_reg == 6'h3f) ? hi_reg : hi_reg + 6'h01;
    end
  a_tap_onehot0: assert property (
    tap_select0 == (64'h1 << wiper_position0))
    else $error("tap select 0 does not match wiper 0");
  a_tap_onehot1: assert property (
    tap_select1 == (64'h1 << wiper_position1))
    else $error("tap select 1 does not match wiper 1");
  a_recall_first: assert property ($fell(rst) |-> ##[0:2]
    (wiper_position0 == NV_INIT[5:0] && wiper_position1 == NV_INIT[29:24]))
    else $error("first stored setting not recalled");
  a_data_low_only: assert property (sda_out == 1'b0)
    else $error("data line driven high");
  a_oe_scl_low: assert property ($changed(sda_oe_n) |-> !scl_in)
    else $error("data line moved while clock high");
  a_oe_hold: assert property ($fell(sda_oe_n) |-> ##1 !sda_oe_n [*8])
    else $error("data line pull too short");
  a_ch_indep: assert property (age_reg == 4'hf |->
    !($changed(wiper_position0) && $changed(wiper_position1)))
    else $error("both wipers changed together");
  // A clock high for 32 cycles or more only happens between frames
  a_idle_still: assert property (age_reg == 4'hf && hi_reg[5] |->
    $stable(wiper_position0) && $stable(wiper_position1))
    else $error("wiper moved with bus idle");
  c_ack: cover property ($fell(sda_oe_n));
  c_w0: cover property (age_reg == 4'hf && $changed(wiper_position0));
  c_top: cover property (wiper_position0 == 6'h3f);
endmodule
bind dwr_bank dwr_bank_properties #(.NV_INIT(NV_INIT)) u_dwr_bank_properties
(
  .ref_clk(ref_clk), .rst(rst), .scl_in(scl_in), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe_n(sda_oe_n),
  .addr_select_bit0(addr_select_bit0), .addr_select_bit1(addr_select_bit1),
  .addr_select_bit2(addr_select_bit2), .addr_select_bit3(addr_select_bit3),
  .wiper_position0(wiper_position0), .wiper_position1(wiper_position1),
  .tap_select0(tap_select0), .tap_select1(tap_select1)
);
`default_nettype wire

// File: verif/dwr_master_model.sv
// Two-wire bus master model: owns the clock, pulls data low or releases.
// Assumes the bench resolves the data wire with a pull-up.
`timescale 1ns/1ps
`default_nettype none
module dwr_master_model
(
  output logic      scl,
  output logic      sda_pull,
  input  wire logic sda
);
  localparam time Q = 40ns;
  // Clock idles high outside frames
  initial
  begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  task automatic put_bit(input logic b);
    sda_pull = ~b;
    #Q scl = 1'b1;
    #(2*Q) scl = 1'b0;
    #Q;
  endtask
  // Released line reads the pull-up unless the device pulls
  task automatic get_bit(output logic b);
    sda_pull = 1'b0;
    #Q scl = 1'b1;
    #Q b = sda;
    #Q scl = 1'b0;
    #Q;
  endtask
  task automatic start;
    sda_pull = 1'b0;
    #Q scl = 1'b1;
    #Q sda_pull = 1'b1;
    #Q scl = 1'b0;
    #Q;
  endtask
  task automatic stop;
    sda_pull = 1'b1;
    #Q scl = 1'b1;
    #Q sda_pull = 1'b0;
    #Q;
  endtask
  task automatic put_byte(input logic [7:0] d, output logic ack);
    for (int i = 7; i >= 0; i--) put_bit(d[i]);
    get_bit(ack);
  endtask
  task automatic get_byte(input logic last, output logic [7:0] d);
    for (int i = 7; i >= 0; i--) get_bit(d[i]);
    put_bit(last);
  endtask
endmodule
`default_nettype wire
